// ==== rtl/mbs_pkg.sv ====
// package: constants, types and carriers for the multi-board sync block
package mbs_pkg;

  // ==========================================================
  // timing
  localparam int unsigned PCLK_NS     = 4;
  localparam int unsigned LK_CLK_NS   = 48;
  localparam int unsigned LK_HALF_CYC = LK_CLK_NS / (2 * PCLK_NS);
  // edges the strap synchroniser needs before its output is real
  localparam logic [1:0]  STRAP_WAIT  = 2'h2;

  // ==========================================================
  // register map (byte addresses)
  localparam int unsigned AW         = 12;
  localparam logic [11:0] ADDR_CMD   = 12'h000;
  localparam logic [11:0] ADDR_CTRL  = 12'h004;
  localparam logic [11:0] ADDR_STAT  = 12'h008;
  localparam logic [31:0] CMD_RESET  = 32'h0000_0000;

  // command codes written to board_command
  localparam logic [31:0] CMD_SYNC_EXCLUDE = 32'h0000_0078;
  localparam logic [31:0] CMD_TRIG_SLAVE   = 32'h0000_006f;
  localparam logic [31:0] CMD_CLK_MASTER   = 32'h0000_0080;
  localparam logic [31:0] CMD_CLK_SLAVE    = 32'h0000_0081;
  localparam logic [31:0] CMD_TRIG_MASTER  = 32'h0000_0082;
  localparam logic [31:0] CMD_CLK_ONLY     = 32'h0000_0083;

  // control register fields
  localparam int unsigned CTRL_HUB_BIT  = 0;
  localparam int unsigned CTRL_SLOT_LSB = 4;
  localparam logic [3:0]  MAX_CASCADE   = 4'h4;
  localparam logic [4:0]  MAX_HUB       = 5'h10;
  localparam logic [2:0]  HUB_OR_REV    = 3'h4;

  // status register fields
  localparam int unsigned ST_EXCL_BIT   = 0;
  localparam int unsigned ST_CLKM_BIT   = 1;
  localparam int unsigned ST_CLKS_BIT   = 2;
  localparam int unsigned ST_TRGM_BIT   = 3;
  localparam int unsigned ST_TRGS_BIT   = 4;
  localparam int unsigned ST_CONLY_BIT  = 5;
  localparam int unsigned ST_ERR_BIT    = 6;
  localparam int unsigned ST_ORAV_BIT   = 7;
  localparam int unsigned ST_DRIVE_BIT  = 8;
  localparam int unsigned ST_SLOT_LSB   = 12;
  localparam int unsigned ST_REV_LSB    = 16;

  // ==========================================================
  // types
  typedef enum logic [1:0] {CLK_NONE, CLK_MASTER, CLK_SLAVE} mbs_clk_role_t;
  typedef enum logic [1:0] {TRG_NONE, TRG_MASTER, TRG_SLAVE, TRG_CLKONLY}
    mbs_trg_role_t;
  typedef enum logic [1:0] {TS_IDLE, TS_WAIT_FALL, TS_DRIVE} mbs_tstate_t;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata;
  } mbs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mbs_apb_rsp_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe_n;
    logic trig_o;
    logic trig_oe_n;
  } mbs_link_out_t;

endpackage : mbs_pkg

// ==== rtl/mbs_sync2.sv ====
// two flip-flop synchroniser for levels coming from outside pclk
`timescale 1ns/1ps
module mbs_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  import mbs_pkg::*;

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } mbs_sync_st_t;

  mbs_sync_st_t st_q;
  mbs_sync_st_t st_d;

  always_comb
  begin
    st_d     = st_q;
    st_d.ff1 = async_i;
    st_d.ff2 = st_q.ff1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_o = st_q.ff2;

endmodule : mbs_sync2

// ==== rtl/mbs_clkdiv.sv ====
// divider that makes the shared sample clock on the clock master
`timescale 1ns/1ps
module mbs_clkdiv (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      clk_o
);
  import mbs_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
  } mbs_div_st_t;

  mbs_div_st_t st_q;
  mbs_div_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (!run)
    begin
      st_d.cnt = 8'h00;
      st_d.clk = 1'b0;
    end
    else if (st_q.cnt == 8'(LK_HALF_CYC - 1))
    begin
      st_d.cnt = 8'h00;
      st_d.clk = ~st_q.clk;
    end
    else
      st_d.cnt = st_q.cnt + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign clk_o = st_q.clk;

endmodule : mbs_clkdiv

// ==== rtl/mbs_sync_core.sv ====
// multi-board clock and trigger synchronisation with apb command port
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module mbs_sync_core (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire mbs_pkg::mbs_apb_req_t apb_req,
  output mbs_pkg::mbs_apb_rsp_t      apb_rsp,
  // sync link pins
  input  wire logic                  lk_clk_i,
  input  wire logic                  lk_trig_n_i,
  output mbs_pkg::mbs_link_out_t     lk_out,
  // hub revision strap
  input  wire logic [2:0]            hub_rev_i,
  // board side
  input  wire logic                  local_trig,
  output logic                       start,
  output logic                       use_link_clk
);
  import mbs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]   cmd;
    logic          hub;
    logic [3:0]    slot;
    logic          excluded;
    mbs_clk_role_t clk_role;
    mbs_trg_role_t trg_role;
    logic          cfg_err;
    mbs_tstate_t   tst;
    logic          lk_clk_prev;
    logic          start;
    logic          strap_done;
    logic [1:0]    strap_cnt;
    logic [2:0]    hub_rev;
    logic [31:0]   prdata;
  } mbs_core_st_t;

  mbs_core_st_t st_q;
  mbs_core_st_t st_d;

  // ==========================================================
  // link input crossing: clock and trigger share one delay
  logic [1:0] lk_s;
  logic [2:0] rev_s;
  logic       div_clk;
  logic       div_run;

  mbs_sync2 #(
    .W (2)
  ) u_lk_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({lk_clk_i, lk_trig_n_i}),
    .sync_o  (lk_s)
  );

  mbs_sync2 #(
    .W (3)
  ) u_rev_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (hub_rev_i),
    .sync_o  (rev_s)
  );

  assign div_run = (st_q.clk_role == CLK_MASTER) && !st_q.excluded;

  mbs_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (div_run),
    .clk_o   (div_clk)
  );

  // ==========================================================
  // decode
  logic        lk_clk_s;
  logic        lk_trig_s;
  logic        lk_rise;
  logic        lk_fall;
  logic        joined;
  logic        share_trig;
  logic        or_avail;
  logic        setup_ph;
  logic        wr_acc;
  logic        hit;
  logic [31:0] rd_val;
  logic [3:0]  new_slot;
  logic        new_hub;
  logic [31:0] status;

  assign lk_clk_s  = lk_s[1];
  assign lk_trig_s = ~lk_s[0];
  assign lk_rise   = lk_clk_s && !st_q.lk_clk_prev;
  assign lk_fall   = !lk_clk_s && st_q.lk_clk_prev;

  // a board takes part only with a clock role and not excluded
  assign joined     = !st_q.excluded && (st_q.clk_role != CLK_NONE);
  assign share_trig = joined && ((st_q.trg_role == TRG_MASTER) ||
                                 (st_q.trg_role == TRG_SLAVE));
  assign or_avail   = st_q.hub && (st_q.hub_rev >= HUB_OR_REV);

  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign hit      = (apb_req.paddr == ADDR_CMD) ||
                    (apb_req.paddr == ADDR_CTRL) ||
                    (apb_req.paddr == ADDR_STAT);

  assign new_hub  = apb_req.pwdata[CTRL_HUB_BIT];
  assign new_slot = apb_req.pwdata[CTRL_SLOT_LSB +: 4];

  always_comb
  begin
    status                    = 32'h0000_0000;
    status[ST_EXCL_BIT]       = st_q.excluded;
    status[ST_CLKM_BIT]       = st_q.clk_role == CLK_MASTER;
    status[ST_CLKS_BIT]       = st_q.clk_role == CLK_SLAVE;
    status[ST_TRGM_BIT]       = st_q.trg_role == TRG_MASTER;
    status[ST_TRGS_BIT]       = st_q.trg_role == TRG_SLAVE;
    status[ST_CONLY_BIT]      = st_q.trg_role == TRG_CLKONLY;
    status[ST_ERR_BIT]        = st_q.cfg_err;
    status[ST_ORAV_BIT]       = or_avail;
    status[ST_DRIVE_BIT]      = st_q.tst == TS_DRIVE;
    status[ST_SLOT_LSB +: 4]  = st_q.slot;
    status[ST_REV_LSB +: 3]   = st_q.hub_rev;
  end

  always_comb
  begin
    case (apb_req.paddr)
      ADDR_CMD:
        rd_val = st_q.cmd;
      ADDR_CTRL:
      begin
        rd_val                     = 32'h0000_0000;
        rd_val[CTRL_HUB_BIT]       = st_q.hub;
        rd_val[CTRL_SLOT_LSB +: 4] = st_q.slot;
      end
      ADDR_STAT:
        rd_val = status;
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_d             = st_q;
    st_d.lk_clk_prev = lk_clk_s;
    st_d.start       = 1'b0;

    // strap sampled once, after its synchroniser has filled; taking it
    // at the first edge would latch the synchroniser's reset zero and
    // hide a hub that can or-combine triggers
    if (!st_q.strap_done)
    begin
      if (st_q.strap_cnt == STRAP_WAIT)
      begin
        st_d.strap_done = 1'b1;
        st_d.hub_rev    = rev_s;
      end
      else
        st_d.strap_cnt = st_q.strap_cnt + 2'h1;
    end

    // read data prepared in the setup cycle, held in a flop
    if (setup_ph)
      st_d.prdata = rd_val;

    // register writes at the access edge
    if (wr_acc && apb_req.paddr == ADDR_CMD)
    begin
      st_d.cmd = apb_req.pwdata;
      case (apb_req.pwdata)
        CMD_SYNC_EXCLUDE:
          st_d.excluded = 1'b1;
        CMD_CLK_MASTER:
        begin
          st_d.clk_role = CLK_MASTER;
          st_d.excluded = 1'b0;
        end
        CMD_CLK_SLAVE:
        begin
          st_d.clk_role = CLK_SLAVE;
          st_d.excluded = 1'b0;
        end
        CMD_TRIG_MASTER:
          st_d.trg_role = TRG_MASTER;
        CMD_TRIG_SLAVE:
          st_d.trg_role = TRG_SLAVE;
        CMD_CLK_ONLY:
          st_d.trg_role = TRG_CLKONLY;
        default:
          st_d.cmd = apb_req.pwdata;
      endcase
    end

    if (wr_acc && apb_req.paddr == ADDR_CTRL)
    begin
      // out-of-range slot is refused and flagged
      if (!new_hub && ({1'b0, new_slot} >= {1'b0, MAX_CASCADE}))
        st_d.cfg_err = 1'b1;
      else if ({1'b0, new_slot} >= MAX_HUB)
        st_d.cfg_err = 1'b1;
      else
      begin
        st_d.hub  = new_hub;
        st_d.slot = new_slot;
      end
    end

    // writing one to the error bit clears it; a new error wins
    if (wr_acc && apb_req.paddr == ADDR_STAT &&
        apb_req.pwdata[ST_ERR_BIT] && st_d.cfg_err == st_q.cfg_err)
      st_d.cfg_err = 1'b0;

    // trigger master: drive the line from one link fall to the next,
    // so exactly one rising edge sees it
    case (st_q.tst)
      TS_IDLE:
      begin
        if (local_trig && share_trig && st_q.trg_role == TRG_MASTER)
          st_d.tst = TS_WAIT_FALL;
      end
      TS_WAIT_FALL:
      begin
        if (!share_trig)
          st_d.tst = TS_IDLE;
        else if (lk_fall)
        begin
          // without the or-combine another master's pulse owns the line
          if (lk_trig_s && !or_avail)
            st_d.tst = TS_IDLE;
          else
            st_d.tst = TS_DRIVE;
        end
      end
      TS_DRIVE:
      begin
        if (lk_fall || !share_trig)
          st_d.tst = TS_IDLE;
      end
      default:
        st_d.tst = TS_IDLE;
    endcase

    // start: shared link edge when joined as trigger master or slave, local trigger otherwise
    if (share_trig)
      st_d.start = lk_rise && lk_trig_s;
    else
      st_d.start = local_trig;
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q             <= '0;
      st_q.cmd         <= CMD_RESET;
      st_q.clk_role    <= CLK_NONE;
      st_q.trg_role    <= TRG_NONE;
      st_q.tst         <= TS_IDLE;
    end
    else
      st_q <= st_d;
  end

  // ==========================================================
  // outputs
  assign apb_rsp.prdata  = st_q.prdata;
  // zero wait states: every register answers in its access cycle
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !hit;

  // only the clock master drives the shared clock
  assign lk_out.clk_o     = div_clk;
  assign lk_out.clk_oe_n  = !div_run;
  // open-drain trigger, asserted low
  assign lk_out.trig_o    = 1'b0;
  assign lk_out.trig_oe_n = st_q.tst != TS_DRIVE;

  assign start        = st_q.start;
  assign use_link_clk = (st_q.clk_role == CLK_SLAVE) && !st_q.excluded;

endmodule : mbs_sync_core

// ==== verification/mbs_sync_core_properties.sv ====
// checker: port-level properties of the sync core
`timescale 1ns/1ps
module mbs_sync_chk
  import mbs_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire mbs_pkg::mbs_apb_req_t  apb_req,
  input wire mbs_pkg::mbs_apb_rsp_t  apb_rsp,
  input wire mbs_pkg::mbs_link_out_t lk_out,
  input wire logic                   start,
  input wire logic                   use_link_clk
);
  // ==========================================================
  // access decode
  logic acc;
  logic map;
  logic wcmd;
  assign acc = apb_req.psel && apb_req.penable;
  assign map = apb_req.paddr inside {ADDR_CMD, ADDR_CTRL, ADDR_STAT};
  assign wcmd = acc && apb_req.pwrite && apb_req.paddr == ADDR_CMD;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  property p_rdy; acc |-> apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_err; acc && !map |-> apb_rsp.pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ok; acc && map |-> !apb_rsp.pslverr; endproperty
  a_ok: assert property (p_ok) else $error("spurious slave error");
  property p_exc;
    wcmd && apb_req.pwdata == CMD_SYNC_EXCLUDE |->
      ##2 (lk_out.clk_oe_n && lk_out.trig_oe_n && !use_link_clk);
  endproperty
  a_exc: assert property (p_exc) else $error("exclude ignored");
  property p_cm;
    wcmd && apb_req.pwdata == CMD_CLK_MASTER |-> ##2 !lk_out.clk_oe_n;
  endproperty
  a_cm: assert property (p_cm) else $error("master not driving");
  property p_one; use_link_clk |-> lk_out.clk_oe_n; endproperty
  a_one: assert property (p_one) else $error("slave drives clock");
  property p_hold; $fell(lk_out.trig_oe_n) |-> !lk_out.trig_oe_n[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("trigger too short");
  property p_rel; $fell(lk_out.trig_oe_n) |-> ##[9:15] lk_out.trig_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("trigger too long");
  property p_go; $fell(lk_out.trig_oe_n) |-> ##[1:14] start; endproperty
  a_go: assert property (p_go) else $error("no start on link");
  property p_pls; start |=> !start; endproperty
  a_pls: assert property (p_pls) else $error("start not a pulse");
endmodule : mbs_sync_chk

bind mbs_sync_core mbs_sync_chk u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .lk_out(lk_out), .start(start),
  .use_link_clk(use_link_clk)
);

// ==== verification/mbs_board_model.sv ====
// model of a neighbouring board on the shared sync link
`timescale 1ns/1ps
module mbs_board_model (
  input  wire logic clk_en,
  input  wire logic fire,
  input  wire logic lk_clk,
  output logic      clk_o,
  output logic      pull
);
  // ==========================================================
  // sample clock, phase unrelated to pclk; terminated low when off
  initial
  begin
    clk_o = 1'b0;
    #1.3;
    forever
    begin
      #24;
      clk_o = clk_en ? ~clk_o : 1'b0;
    end
  end
  // ==========================================================
  // trigger master: pull the line for one link period from a fall
  initial
  begin
    pull = 1'b0;
    forever
    begin
      @(posedge fire);
      @(negedge lk_clk);
      pull = 1'b1;
      @(negedge lk_clk);
      pull = 1'b0;
    end
  end
endmodule : mbs_board_model

// ==== verification/mbs_sync_core_tb.sv ====
// testbench for the multi-board sync core
`timescale 1ns/1ps
module mbs_sync_core_tb;
  import mbs_pkg::*;
  logic          pclk = 0;
  logic          presetn = 0;
  logic          lt = 0;
  logic          en = 0;
  logic          fire = 0;
  logic          st, ulc, mclk, pull, lkc, lkt;
  logic [2:0]    rev = 3'h0;
  mbs_apb_req_t  rq = '0;
  mbs_apb_rsp_t  rsp;
  mbs_link_out_t lo;
  logic [32:0]   q_rd[$];
  bit            q_st[$];
  int            n_mismatch, tests_run, cyc;
  int            seed = 24;
  logic [31:0]   cmds[6] = '{CMD_SYNC_EXCLUDE, CMD_TRIG_SLAVE,
    CMD_CLK_MASTER, CMD_CLK_SLAVE, CMD_TRIG_MASTER, CMD_CLK_ONLY};

  always #2 pclk = ~pclk;
  // open-drain trigger with pull-up; clock from whichever board masters
  assign lkc = !lo.clk_oe_n ? lo.clk_o : mclk;
  assign lkt = !((!lo.trig_oe_n && !lo.trig_o) || pull);

  mbs_sync_core uut (.pclk(pclk), .presetn(presetn), .apb_req(rq),
    .apb_rsp(rsp), .lk_clk_i(lkc), .lk_trig_n_i(lkt), .lk_out(lo),
    .hub_rev_i(rev), .local_trig(lt), .start(st), .use_link_clk(ulc));
  mbs_board_model peer (.clk_en(en), .fire(fire), .lk_clk(lkc),
    .clk_o(mclk), .pull(pull));

  // ==========================================================
  // tasks
  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    rq.psel <= 1'b1;
    rq.pwrite <= w;
    rq.paddr <= a;
    rq.pwdata <= d;
    @(posedge pclk);
    rq.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [32:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task pulse;
    q_st.push_back(1'b1);
    @(posedge pclk);
    lt <= 1'b1;
    @(posedge pclk);
    lt <= 1'b0;
  endtask : pulse

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // ==========================================================
  // result monitor: oldest note against each result
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      end_sim();
    end
    else
    begin
      if (rq.psel && rq.penable && rsp.pready && !rq.pwrite)
        chk("prdata", q_rd.pop_front(), {rsp.pslverr, rsp.prdata});
      if (st === 1'b1)
      begin
        chk("start", 33'h1, 33'(q_st.size() > 0));
        if (q_st.size() > 0)
          q_st.delete(0);
      end
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    rev <= 3'($random(seed));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CMD, {1'b0, CMD_RESET});
    rd(12'hffc, 33'h1_0000_0000);
    foreach (cmds[i])
    begin
      apb(1'b1, ADDR_CMD, cmds[i]);
      rd(ADDR_CMD, {1'b0, cmds[i]});
    end
    $display("test registers done");
    en <= 1'b1;
    apb(1'b1, ADDR_CMD, CMD_CLK_SLAVE);
    apb(1'b1, ADDR_CMD, CMD_TRIG_SLAVE);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("use_link_clk", 33'h1, 33'(ulc));
    chk("clk_oe_n", 33'h1, 33'(lo.clk_oe_n));
    q_st.push_back(1'b1);
    @(posedge pclk);
    fire <= 1'b1;
    repeat (40) @(posedge pclk);
    fire <= 1'b0;
    chk("pending", 33'h0, 33'(q_st.size()));
    $display("test clock slave done");
    en <= 1'b0;
    apb(1'b1, ADDR_CMD, CMD_CLK_MASTER);
    apb(1'b1, ADDR_CMD, CMD_TRIG_MASTER);
    @(negedge pclk);
    chk("clk_oe_n", 33'h0, 33'(lo.clk_oe_n));
    chk("use_link_clk", 33'h0, 33'(ulc));
    repeat ($random(seed) & 15) @(posedge pclk);
    pulse();
    repeat (40) @(posedge pclk);
    chk("pending", 33'h0, 33'(q_st.size()));
    $display("test trigger master done");
    apb(1'b1, ADDR_CMD, CMD_CLK_ONLY);
    pulse();
    repeat (4) @(posedge pclk);
    chk("pending", 33'h0, 33'(q_st.size()));
    $display("test clock only done");
    apb(1'b1, ADDR_CMD, CMD_SYNC_EXCLUDE);
    @(negedge pclk);
    chk("clk_oe_n", 33'h1, 33'(lo.clk_oe_n));
    chk("use_link_clk", 33'h0, 33'(ulc));
    pulse();
    repeat (4) @(posedge pclk);
    chk("pending", 33'h0, 33'(q_st.size()));
    $display("test exclude done");
    // hub slot 5 is legal, cascade slot 4 is refused and flagged
    apb(1'b1, ADDR_CTRL, 32'h0000_0051);
    rd(ADDR_CTRL, 33'h0_0000_0051);
    apb(1'b1, ADDR_CTRL, 32'h0000_0040);
    rd(ADDR_CTRL, 33'h0_0000_0051);
    rd(ADDR_STAT, {1'b0, 13'h0, rev, 4'h5, 4'h0, (rev >= HUB_OR_REV),
      1'b1, 6'h23});
    apb(1'b1, ADDR_STAT, 32'h0000_0040);
    rd(ADDR_STAT, {1'b0, 13'h0, rev, 4'h5, 4'h0, (rev >= HUB_OR_REV),
      1'b0, 6'h23});
    $display("test topology done");
    end_sim();
  end
endmodule : mbs_sync_core_tb
